// ===== src/wtpp_engine.sv
// Purpose: Word table push/pop engine: copy-into-table and pop-from-table operations
// Assumes: Scan sequencer strobes OP_START once per scan per enabled operation;
//          word memory answers a read with MEM_RDATA one cycle after MEM_RE
// Notes:   Boundary flag clears at SCAN_END or when the next operation starts
//
// Summary of operation
// R01: Advance pointer by one, then copy source word into the entry it selects.
// R02: Pointer at table length wraps to one on next advance, never zero.
// R03: Pointer word sits at start address; data entries follow it.
// R04: Each operation runs once per scan while its enable is asserted; with both enables set, only copy runs.
// R05: Program supplies table length 0 to FF in first stack level.
// R06: Program supplies table start address in the accumulator.
// R07: Copy accepts pointer 0 to length; otherwise no data moves.
// R08: Copy raises boundary flag when pointer equals table length.
// R09: Boundary flag holds until next flag-driving operation or scan end.
// R10: Pointer starts at 0; first entry written at pointer 1, also after wrap.
// R11: Pop stores top entry at destination, then shifts counted entries up.
// R12: Pop counter at table head decreases by one each execution.
// R13: Pop counter zero or above length: no operation, boundary flag raised.
// R14: Pop raises boundary flag when the counter equals zero.
// R15: Program loads the pop counter itself; no automatic initialisation.
// R16: Pop entries numbered from top; entries beyond count stay in place.
// R17: Program gates enable through a one-shot for single-scan operation.
// R18: Copy computes next pointer first, writes at start plus next pointer.
// R19: Pop leaves lowest counted word unchanged after the shift.
`timescale 1ns/1ns
`default_nettype none
module wtpp_engine
  import wtpp_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        SCAN_END,
  input  wire logic        OP_START,
  input  wire logic        COPY_EN,
  input  wire logic        POP_EN,
  input  wire logic [7:0]  TBL_LEN,
  input  wire logic [15:0] TBL_START,
  input  wire logic [15:0] OPERAND_ADDR,
  input  wire logic [15:0] MEM_RDATA,
  output logic             MEM_RE,
  output logic             MEM_WE,
  output logic [15:0]      MEM_ADDR,
  output logic [15:0]      MEM_WDATA,
  output logic             BUSY,
  output logic             OP_DONE,
  output logic             TABLE_BOUNDARY_FLAG
);

  wtpp_state_t   state_r,   state_nxt;
  wtpp_mem_req_t mem_r,     mem_nxt;
  wtpp_op_args_t args_r,    args_nxt;
  logic          is_pop_r,  is_pop_nxt;
  logic [15:0]   head_r,    head_nxt;
  logic [15:0]   idx_r,     idx_nxt;
  logic          flag_r,    flag_nxt;
  logic          done_r,    done_nxt;
  logic          busy_r,    busy_nxt;

  logic [15:0] len_w;
  logic [15:0] next_ptr;
  logic [15:0] base_w;
  logic [15:0] idx_prev_w;

  function automatic wtpp_mem_req_t mem_cmd(input logic [15:0] a, input logic [15:0] d,
                                            input logic w, input logic r);
    wtpp_mem_req_t q;
    q.addr  = a;
    q.wdata = d;
    q.we    = w;
    q.re    = r;
    return q;
  endfunction

  assign len_w    = {8'h00, args_r.tbl_len};
  assign next_ptr = (head_r == len_w) ? WTPP_ONE : head_r + WTPP_ONE;  // [R02] [R18] [R10]
  assign base_w     = args_r.tbl_start;
  assign idx_prev_w = idx_r - WTPP_ONE;

  // Copy refuses a pointer above the length; pop also refuses a zero count
  function automatic logic head_refused(input logic [15:0] head, input logic [15:0] len,
                                        input logic pop);
    logic refused;
    refused = (head > len);  // [R07] [R13]
    if (pop && head == WTPP_ZERO) begin
      refused = 1'b1;  // [R13]
    end
    return refused;
  endfunction

  // Data entry n sits n words past the pointer word
  function automatic logic [15:0] entry_addr(input logic [15:0] start, input logic [15:0] n);
    return start + n;
  endfunction

  // Memory answers a read on the first edge after the strobe is raised, so
  // every read is followed by one wait state before its data is used.
  // Copy:  head read, wait, check, source read, pointer write during the
  //        wait, entry write with the source word, then flag and done.
  // Pop:   head read, wait, check, then per counted entry a read, a wait and
  //        a write one place up (the top entry goes to the destination),
  //        then the count write, then flag and done.
  // Every memory write is issued while busy is still high and lands no
  // later than the edge that raises done, so the caller may read at once.
  always_comb begin
    state_nxt  = state_r;
    mem_nxt    = mem_cmd(mem_r.addr, mem_r.wdata, 1'b0, 1'b0);
    args_nxt   = args_r;
    is_pop_nxt = is_pop_r;
    head_nxt   = head_r;
    idx_nxt    = idx_r;
    flag_nxt   = flag_r;
    done_nxt   = 1'b0;
    busy_nxt   = busy_r;
    if (SCAN_END) begin
      flag_nxt = 1'b0;  // [R09]
    end
    case (state_r)
      WTPP_IDLE: begin
        // One start strobe per scan runs the enabled operation once
        if (OP_START && (COPY_EN || POP_EN)) begin  // [R04]
          args_nxt.tbl_len   = TBL_LEN;       // [R05]
          args_nxt.tbl_start = TBL_START;     // [R06]
          args_nxt.operand   = OPERAND_ADDR;
          is_pop_nxt = POP_EN && !COPY_EN;
          flag_nxt   = 1'b0;  // [R09]
          busy_nxt   = 1'b1;
          mem_nxt    = mem_cmd(TBL_START, WTPP_ZERO, 1'b0, 1'b1);  // [R03]
          state_nxt  = WTPP_RD_HEAD;
        end
      end

      WTPP_RD_HEAD: begin
        state_nxt = WTPP_WT_HEAD;
      end

      WTPP_WT_HEAD: begin
        head_nxt = MEM_RDATA;  // [R15]
        if (head_refused(MEM_RDATA, len_w, is_pop_r)) begin  // [R07] [R13]
          if (is_pop_r) begin
            flag_nxt = 1'b1;  // [R13]
          end
          state_nxt = WTPP_IDLE;
          busy_nxt  = 1'b0;
          done_nxt  = 1'b1;
        end else if (!is_pop_r) begin
          mem_nxt   = mem_cmd(args_r.operand, WTPP_ZERO, 1'b0, 1'b1);
          state_nxt = WTPP_RD_SRC;
        end else begin
          mem_nxt   = mem_cmd(entry_addr(base_w, WTPP_ONE), WTPP_ZERO, 1'b0, 1'b1);  // [R11]
          idx_nxt   = WTPP_ONE;
          state_nxt = WTPP_RD_TOP;
        end
      end

      WTPP_RD_SRC: begin
        // Source read is in flight; the advanced pointer is stored meanwhile
        head_nxt  = next_ptr;  // [R01] [R02] [R18]
        mem_nxt   = mem_cmd(base_w, next_ptr, 1'b1, 1'b0);  // [R03]
        state_nxt = WTPP_WR_ENTRY;
      end

      WTPP_WR_ENTRY: begin
        mem_nxt   = mem_cmd(entry_addr(base_w, head_r), MEM_RDATA, 1'b1, 1'b0);  // [R01] [R18]
        state_nxt = WTPP_WR_HEAD;
      end

      WTPP_RD_TOP: begin
        state_nxt = WTPP_SHIFT_RD;
      end

      WTPP_SHIFT_RD: begin
        if (idx_r == WTPP_ONE) begin
          mem_nxt = mem_cmd(args_r.operand, MEM_RDATA, 1'b1, 1'b0);  // [R11]
        end else begin
          mem_nxt = mem_cmd(entry_addr(base_w, idx_prev_w), MEM_RDATA, 1'b1, 1'b0);  // [R16]
        end
        state_nxt = WTPP_SHIFT_WR;
      end

      WTPP_SHIFT_WR: begin
        if (idx_r < head_r) begin  // [R16]
          mem_nxt   = mem_cmd(entry_addr(base_w, idx_r + WTPP_ONE), WTPP_ZERO, 1'b0, 1'b1);
          idx_nxt   = idx_r + WTPP_ONE;
          state_nxt = WTPP_RD_TOP;
        end else begin
          // Entry at the old count keeps its word
          head_nxt  = head_r - WTPP_ONE;  // [R12] [R19]
          mem_nxt   = mem_cmd(base_w, head_r - WTPP_ONE, 1'b1, 1'b0);  // [R03] [R12]
          state_nxt = WTPP_WR_HEAD;
        end
      end

      WTPP_WR_HEAD: begin
        // Flag moves together with done; a set here wins over a scan-end clear
        if (is_pop_r) begin
          flag_nxt = (head_r == WTPP_ZERO);  // [R14]
        end else begin
          flag_nxt = (head_r == len_w);  // [R08]
        end
        state_nxt = WTPP_IDLE;
        busy_nxt  = 1'b0;
        done_nxt  = 1'b1;
      end

      default: begin
        state_nxt = WTPP_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r  <= WTPP_IDLE;
      mem_r    <= '0;
      args_r   <= '0;
      is_pop_r <= 1'b0;
      head_r   <= WTPP_PTR_START;
      idx_r    <= WTPP_ZERO;
      flag_r   <= 1'b0;
      done_r   <= 1'b0;
      busy_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      mem_r    <= mem_nxt;
      args_r   <= args_nxt;
      is_pop_r <= is_pop_nxt;
      head_r   <= head_nxt;
      idx_r    <= idx_nxt;
      flag_r   <= flag_nxt;
      done_r   <= done_nxt;
      busy_r   <= busy_nxt;
    end
  end

  always_comb begin
    MEM_RE              = mem_r.re;
    MEM_WE              = mem_r.we;
    MEM_ADDR            = mem_r.addr;
    MEM_WDATA           = mem_r.wdata;
    BUSY                = busy_r;
    OP_DONE             = done_r;
    TABLE_BOUNDARY_FLAG = flag_r;
  end

endmodule
`default_nettype wire

// ===== src/wtpp_pkg.sv
// Purpose: Shared constants and types for the word table push/pop engine
// Assumes: 16-bit words, word addresses as wide as the word
// Notes:   Table length is an 8-bit count from the first stack level
package wtpp_pkg;

  localparam int unsigned WTPP_WORD_W = 16;
  localparam int unsigned WTPP_LEN_W  = 8;

  localparam logic [15:0] WTPP_ONE       = 16'h0001;
  localparam logic [15:0] WTPP_ZERO      = 16'h0000;
  localparam logic [15:0] WTPP_PTR_START = 16'h0000;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
  } wtpp_mem_req_t;

  typedef struct packed {
    logic [7:0]  tbl_len;
    logic [15:0] tbl_start;
    logic [15:0] operand;
  } wtpp_op_args_t;

  typedef enum logic [8:0] {
    WTPP_IDLE     = 9'b0_0000_0001,
    WTPP_RD_HEAD  = 9'b0_0000_0010,
    WTPP_WT_HEAD  = 9'b0_0000_0100,
    WTPP_RD_SRC   = 9'b0_0000_1000,
    WTPP_WR_ENTRY = 9'b0_0001_0000,
    WTPP_RD_TOP   = 9'b0_0010_0000,
    WTPP_SHIFT_RD = 9'b0_0100_0000,
    WTPP_SHIFT_WR = 9'b0_1000_0000,
    WTPP_WR_HEAD  = 9'b1_0000_0000
  } wtpp_state_t;

endpackage

// ===== verification/wtpp_mem_model.sv
// Purpose: Word memory on the far side of the table engine
// Assumes: Read data returns one cycle after the read strobe
// Notes:   Between reads the data lines toggle so a stale word reads inverted one cycle later
`timescale 1ns/1ns
`default_nettype none
module wtpp_mem_model (
  input  wire logic        clk,
  input  wire logic        re,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata
);
  logic [15:0] mem_r [512];
  initial rdata = 16'h0000;
  always @(posedge clk) begin
    if (we) mem_r[addr[8:0]] <= wdata;
    rdata <= re ? mem_r[addr[8:0]] : ~rdata;
  end
endmodule
`default_nettype wire

// ===== verification/wtpp_engine_chk.sv
// Purpose: Port checks for the table engine
// Assumes: One clock domain
// Notes:   Bound onto every engine instance
`timescale 1ns/1ns
`default_nettype none
module wtpp_engine_chk (
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic        SCAN_END,
  input wire logic        OP_START,
  input wire logic        COPY_EN,
  input wire logic        POP_EN,
  input wire logic [15:0] TBL_START,
  input wire logic        MEM_RE,
  input wire logic        MEM_WE,
  input wire logic [15:0] MEM_ADDR,
  input wire logic        BUSY,
  input wire logic        OP_DONE,
  input wire logic        TABLE_BOUNDARY_FLAG
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  wire logic go = OP_START && (COPY_EN || POP_EN) && !BUSY;
  start_busy_a: assert property (go |=> BUSY) else $error("busy missing");
  idle_stay_a: assert property (!BUSY && !OP_START |=> !BUSY) else $error("busy unasked");
  head_first_a: assert property (go && COPY_EN |=> MEM_RE && MEM_ADDR == $past(TBL_START))
    else $error("head not read");
  copy_time_a: assert property (go && COPY_EN |-> ##[3:6] OP_DONE) else $error("copy late");
  strobe_busy_a: assert property (MEM_RE || MEM_WE |-> BUSY && !(MEM_RE && MEM_WE))
    else $error("strobe outside op");
  done_pulse_a: assert property (OP_DONE |=> !OP_DONE) else $error("done too long");
  scan_clear_a: assert property (SCAN_END && !BUSY |=> !TABLE_BOUNDARY_FLAG)
    else $error("flag kept");
  flag_hold_a: assert property ($changed(TABLE_BOUNDARY_FLAG) |->
    OP_DONE || $past(SCAN_END) || $past(OP_START)) else $error("flag moved");
endmodule
bind wtpp_engine wtpp_engine_chk chk_u (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .SCAN_END(SCAN_END), .OP_START(OP_START), .COPY_EN(COPY_EN), .POP_EN(POP_EN),
  .TBL_START(TBL_START), .MEM_RE(MEM_RE), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
  .BUSY(BUSY), .OP_DONE(OP_DONE), .TABLE_BOUNDARY_FLAG(TABLE_BOUNDARY_FLAG));
`default_nettype wire

// ===== verification/wtpp_engine_bench.sv
// Purpose: Self-checking bench for the table engine
// Assumes: Table head at 0040, operand word at 0080
// Notes:   Rows cover plain cases, hand tests the rest
`timescale 1ns/1ns
`default_nettype none
module wtpp_engine_bench;
  import wtpp_pkg::*;
  typedef struct packed {
    logic pop; logic [7:0] len; logic [15:0] head; logic [15:0] nhead; logic flag;
    logic [15:0] dat;
  } wtpp_row_t;
  logic clk = 1'b0, rst_n = 1'b0, scan_end = 1'b0, op_start = 1'b0, copy_en = 1'b0;
  logic pop_en = 1'b0, re, we, busy, done, flag;
  logic [7:0]  len = 8'h06;
  logic [15:0] rdata, maddr, wdata;
  int bad_count = 0, n_compared = 0;
  wtpp_row_t rows [9] = '{
    '{1'b0, 8'h06, 16'h0000, 16'h0001, 1'b0, 16'h5555},
    '{1'b0, 8'h06, 16'h0005, 16'h0006, 1'b1, 16'h5555},
    '{1'b0, 8'h06, 16'h0006, 16'h0001, 1'b0, 16'h5555},
    '{1'b0, 8'h06, 16'h0007, 16'h0007, 1'b0, 16'hA007},
    '{1'b0, 8'hFF, 16'h00FE, 16'h00FF, 1'b1, 16'h5555},
    '{1'b1, 8'h06, 16'h0001, 16'h0000, 1'b1, 16'hA001},
    '{1'b1, 8'h06, 16'h0000, 16'h0000, 1'b1, 16'h5555},
    '{1'b1, 8'h06, 16'h0007, 16'h0007, 1'b1, 16'h5555},
    '{1'b1, 8'h06, 16'h0004, 16'h0003, 1'b0, 16'hA001}};
  wtpp_engine dut_u (.CORE_CLK(clk), .RST_N(rst_n), .SCAN_END(scan_end), .OP_START(op_start),
    .COPY_EN(copy_en), .POP_EN(pop_en), .TBL_LEN(len), .TBL_START(16'h0040),
    .OPERAND_ADDR(16'h0080), .MEM_RDATA(rdata), .MEM_RE(re), .MEM_WE(we), .MEM_ADDR(maddr),
    .MEM_WDATA(wdata), .BUSY(busy), .OP_DONE(done), .TABLE_BOUNDARY_FLAG(flag));
  wtpp_mem_model mem_u (.clk(clk), .re(re), .we(we), .addr(maddr), .wdata(wdata),
    .rdata(rdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic pop, input logic [15:0] head);
    mem_u.mem_r[9'h040] = head;
    @(negedge clk);
    {op_start, copy_en, pop_en} = {1'b1, !pop, pop};
    @(negedge clk);
    op_start = 1'b0;
    for (int i = 0; i < 60 && done !== 1'b1; i++) @(negedge clk);
    chk({15'h0000, done}, 16'h0001);
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial forever #20 clk = ~clk;
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[r]) begin
      for (int i = 1; i < 9; i++) mem_u.mem_r[9'h040 + i] = 16'(16'hA000 + i);
      mem_u.mem_r[9'h080] = 16'h5555;
      len = rows[r].len;
      run(rows[r].pop, rows[r].head);
      chk(mem_u.mem_r[9'h040], rows[r].nhead);
      chk({15'h0000, flag}, {15'h0000, rows[r].flag});
      chk(mem_u.mem_r[rows[r].pop ? 9'h080 : 9'h040 + rows[r].nhead[8:0]], rows[r].dat);
    end
    for (int k = 1; k < 6; k++) chk(mem_u.mem_r[9'h040 + k], 16'(16'hA000 + k + (k < 4)));
    len = 8'h06;
    run(1'b0, 16'h0005);
    run(1'b0, mem_u.mem_r[9'h040]);
    chk({15'h0000, flag}, 16'h0000);
    chk(mem_u.mem_r[9'h040], 16'h0001);
    run(1'b0, 16'h0005);
    scan_end = 1'b1;
    @(negedge clk);
    scan_end = 1'b0;
    chk({15'h0000, flag}, 16'h0000);
    {op_start, copy_en, pop_en} = 3'b100;
    repeat (6) @(negedge clk);
    op_start = 1'b0;
    chk({15'h0000, busy}, 16'h0000);
    run(1'b0, 16'h0002);
    run(1'b0, 16'h0002);
    chk(mem_u.mem_r[9'h040], 16'h0003);
    mem_u.mem_r[9'h040] = 16'h0002;
    {op_start, copy_en, pop_en} = 3'b111;
    @(negedge clk);
    op_start = 1'b0;
    repeat (10) @(negedge clk);
    chk(mem_u.mem_r[9'h040], 16'h0003);
    @(negedge clk);
    op_start = 1'b1;
    @(negedge clk);
    {op_start, rst_n} = 2'b00;
    @(negedge clk);
    chk({11'h000, busy, done, flag, we, re}, 16'h0000);
    rst_n = 1'b1;
    give_verdict();
  end
endmodule
`default_nettype wire
